// file: hw/tat_throttle_ctrl.sv
// Package thermal alarm line, trip output, critical status and
// per-core clock modulation control.
// Assumes all control inputs except the alarm pin are on sys_clk.
`timescale 1ns/100ps
`default_nettype none
// Operation
// RQ1: Alarm line is input-only after reset
// RQ2: Output-only mode drives, never samples line
// RQ3: External alarm forces lowest performance state
// RQ4: External alarm never starts clock modulation
// RQ5: Lowest state held while line stays asserted
// RQ6: Optional interrupts on alarm assert and release
// RQ7: Own drive hides external alarm until release
// RQ8: External alarm response within 100 us
// RQ9: Consecutive alarms step maximum ratio down
// RQ10: Demotion only in input-only mode
// RQ11: Drive drops in deep idle, returns on wake
// RQ12: Catastrophic heat trips and shuts package down
// RQ13: Critical status plus sticky bit, optional interrupt
// RQ14: Circuit duty overrides software duty
// RQ15: Legacy I/O duty beats per-core duty
// RQ16: Per-core enable bit starts modulation immediately
// RQ17: Duty code field, 12.5 or 6.25 percent
// RQ18: Per-core control gates each core separately
// RQ19: Legacy I/O gates all cores together
// RQ20: Input-only response begins within 1 us
// RQ21: Circuit modulation 25 percent of 32 us
// RQ22: Consecutive means within window; one-step demotion
module tat_throttle_ctrl #(
  parameter int unsigned CONSEC_WIN_CYC = tat_pkg::CONSEC_WIN_CYC_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Configuration
  input wire tat_pkg::tat_mode_e mode_sel,
  input wire logic int_assert_en,
  input wire logic int_deassert_en,
  input wire logic crit_irq_en,
  // Thermal sensing
  input wire logic tcc_active,
  input wire logic tcc_mod_req,
  input wire logic temp_high,
  input wire logic cat_temp_reached,
  input wire logic pkg_deep_idle,
  input wire logic crit_sticky_clr,
  // Open-drain alarm line
  input wire logic alarm_line_n_in,
  output logic alarm_line_n_out,
  output logic alarm_line_n_oe,
  // Performance limits
  input wire tat_pkg::tat_ratio_t max_ratio_nominal,
  input wire tat_pkg::tat_ratio_t lowest_ratio,
  output logic force_lowest_perf,
  output tat_pkg::tat_ratio_t max_ratio_limit,
  // Events and status
  output logic alarm_assert_irq,
  output logic alarm_deassert_irq,
  output logic thermal_irq,
  output logic crit_status,
  output logic crit_sticky,
  output logic thermal_trip_n,
  output logic pkg_shutdown,
  // On-demand modulation
  input wire tat_pkg::tat_ctrl_t [tat_pkg::NUM_CORES-1:0] core_duty_ctrl,
  input wire logic io_mod_en,
  input wire logic [2:0] io_duty,
  output logic duty_fine_cap,
  output logic [tat_pkg::NUM_CORES-1:0] core_clk_run
);
  import tat_pkg::*;

  localparam int RESP_BOUND = QUICK_RESP_CYC;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic tat_ratio_t ratio_down(input tat_ratio_t cur,
                                            input tat_ratio_t floor_r);
    ratio_down = (cur > floor_r + RATIO_STEP) ? cur - RATIO_STEP : floor_r;
  endfunction

  function automatic tat_ratio_t ratio_up(input tat_ratio_t cur,
                                          input tat_ratio_t ceil_r);
    ratio_up = (cur + RATIO_STEP < ceil_r) ? cur + RATIO_STEP : ceil_r;
  endfunction

  // ---------------------------------------------------------------
  // Mode and alarm pin synchroniser
  // ---------------------------------------------------------------
  tat_mode_e mode_q;
  logic alarm_meta;
  logic alarm_sync_n;
  logic [1:0] mask_cnt;
  logic [WIN_W-1:0] win_cnt;
  logic [6:0] slot_cyc;
  tat_slot_t slot_idx;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= TAT_IN_ONLY; // RQ1
      alarm_meta <= 1'b1;
      alarm_sync_n <= 1'b1;
    end else begin
      mode_q <= mode_sel;
      alarm_meta <= alarm_line_n_in;
      alarm_sync_n <= alarm_meta;
    end
  end

  wire logic in_only = (mode_q == TAT_IN_ONLY);
  wire logic can_drive = (mode_q != TAT_IN_ONLY); // RQ1
  // Deep idle removes power from the drive; it returns on wake if hot
  wire logic next_drive = tcc_active & ~pkg_deep_idle & can_drive; // RQ11
  // The synchroniser still shows our own low level for a few cycles
  // after release, so sampling waits until that echo has drained.
  wire logic ext_visible = (mode_q != TAT_OUT_ONLY) & // RQ2
                           ~alarm_line_n_oe & (mask_cnt == 2'h0); // RQ7
  wire logic ext_alarm = ext_visible & ~alarm_sync_n;
  wire logic ext_rise = ext_alarm & ~force_lowest_perf;
  wire logic ext_fall = ~ext_alarm & force_lowest_perf;
  wire logic win_open = (win_cnt != '0);
  wire logic win_last = (win_cnt == WIN_W'(1));
  wire tat_ratio_t cap_down = ratio_down(max_ratio_limit, lowest_ratio);
  wire tat_ratio_t cap_up = ratio_up(max_ratio_limit, max_ratio_nominal);
  wire logic crit_now = tcc_active & temp_high;
  wire logic slot_end = (slot_cyc == SLOT_LAST);
  wire logic tcc_mod_on = tcc_active & tcc_mod_req; // RQ4

  // ---------------------------------------------------------------
  // Alarm line drive
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_line_n_out <= 1'b0;
      alarm_line_n_oe <= 1'b0;
      mask_cnt <= 2'h0;
    end else begin
      alarm_line_n_out <= 1'b0;
      alarm_line_n_oe <= next_drive; // RQ2 RQ11
      if (alarm_line_n_oe) begin
        mask_cnt <= ECHO_MASK;
      end else if (mask_cnt != 2'h0) begin
        mask_cnt <= mask_cnt - 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // External alarm response and edge interrupts
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      force_lowest_perf <= 1'b0;
      alarm_assert_irq <= 1'b0;
      alarm_deassert_irq <= 1'b0;
    end else begin
      force_lowest_perf <= ext_alarm; // RQ3 RQ5 RQ8 RQ20
      alarm_assert_irq <= ext_rise & int_assert_en; // RQ6
      alarm_deassert_irq <= ext_fall & int_deassert_en; // RQ6
    end
  end

  // ---------------------------------------------------------------
  // Maximum ratio demotion
  // ---------------------------------------------------------------
  // Each recovery step below nominal reopens the window, so the ceiling climbs back
  // one step per quiet window and a fresh alarm then demotes again.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      max_ratio_limit <= '0;
      win_cnt <= '0;
    end else if (!in_only) begin
      max_ratio_limit <= max_ratio_nominal; // RQ10
      win_cnt <= '0;
    end else if (ext_rise) begin
      if (win_open) begin
        max_ratio_limit <= cap_down; // RQ9 RQ22
      end
      win_cnt <= '0;
    end else if (ext_fall) begin
      win_cnt <= WIN_W'(CONSEC_WIN_CYC); // RQ22
    end else if (win_last) begin
      max_ratio_limit <= cap_up; // RQ9
      win_cnt <= (cap_up < max_ratio_nominal) ?
                 WIN_W'(CONSEC_WIN_CYC) : '0;
    end else if (win_open) begin
      win_cnt <= win_cnt - WIN_W'(1);
    end else if (!force_lowest_perf) begin
      max_ratio_limit <= max_ratio_nominal;
    end
  end

  // ---------------------------------------------------------------
  // Trip, critical status
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      thermal_trip_n <= 1'b1;
      pkg_shutdown <= 1'b0;
      crit_status <= 1'b0;
      crit_sticky <= 1'b0;
      thermal_irq <= 1'b0;
      duty_fine_cap <= 1'b0;
    end else begin
      // Latched until reset: the package is not trusted to run on
      if (cat_temp_reached) begin
        thermal_trip_n <= 1'b0; // RQ12
        pkg_shutdown <= 1'b1; // RQ12
      end
      crit_status <= crit_now; // RQ13
      crit_sticky <= crit_now | (crit_sticky & ~crit_sticky_clr); // RQ13
      thermal_irq <= crit_now & ~crit_status & crit_irq_en; // RQ13
      duty_fine_cap <= DUTY_FINE_CAP; // RQ17
    end
  end

  // ---------------------------------------------------------------
  // Modulation period: 16 slots over 32 us
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_cyc <= 7'h00;
      slot_idx <= 4'h0;
    end else begin
      slot_cyc <= slot_end ? 7'h00 : slot_cyc + 7'h01; // RQ21
      if (slot_end) begin
        slot_idx <= slot_idx + 4'h1;
      end
    end
  end

  for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
    tat_core_gate u_gate ( // RQ18 RQ19
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .slot_idx(slot_idx),
      .tcc_mod_on(tcc_mod_on),
      .io_mod_en(io_mod_en),
      .io_duty(io_duty),
      .core_ctrl(core_duty_ctrl[c]),
      .core_run(core_clk_run[c])
    );
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_IN_NO_DRIVE: assert property ( // RQ1
    in_only |=> !alarm_line_n_oe)
    else $error("alarm line driven in input-only mode");
  AST_OUT_NO_SAMPLE: assert property ( // RQ2
    mode_q == TAT_OUT_ONLY |=> !force_lowest_perf)
    else $error("alarm line sampled in output-only mode");
  AST_QUICK_RESP: assert property ( // RQ20
    (in_only && !alarm_line_n_in)[*6] |-> ##[0:RESP_BOUND] force_lowest_perf)
    else $error("input-only alarm response too slow");
  AST_NO_EXT_MOD: assert property ( // RQ4
    !tcc_active && !io_mod_en && !core_duty_ctrl[0][MOD_EN_BIT]
    |=> core_clk_run[0])
    else $error("core gated without a modulation request");
  AST_HOLD_LOW: assert property ( // RQ5
    ext_visible && !$past(alarm_line_n_in, 2) |=> force_lowest_perf)
    else $error("lowest state left while alarm held");
  AST_ASSERT_IRQ: assert property ( // RQ6
    $rose(force_lowest_perf) && $past(int_assert_en) |-> alarm_assert_irq)
    else $error("missing alarm assertion interrupt");
  AST_DEASSERT_IRQ: assert property ( // RQ6
    $fell(force_lowest_perf) && $past(int_deassert_en) |-> alarm_deassert_irq)
    else $error("missing alarm release interrupt");
  AST_BLIND_DRIVE: assert property ( // RQ7
    alarm_line_n_oe |=> !force_lowest_perf)
    else $error("external alarm seen during own drive");
  AST_EXT_RESP: assert property ( // RQ8
    $fell(alarm_sync_n) && ext_visible |-> ##[1:2] force_lowest_perf)
    else $error("external alarm response late");
  AST_DEMOTE: assert property ( // RQ9
    in_only && ext_rise && win_open && max_ratio_limit > lowest_ratio
    |=> max_ratio_limit < $past(max_ratio_limit))
    else $error("consecutive alarm did not demote ratio");
  AST_DEMOTE_MODE: assert property ( // RQ10
    !in_only |=> max_ratio_limit == $past(max_ratio_nominal))
    else $error("demotion active outside input-only mode");
  AST_IDLE_DRIVE: assert property ( // RQ11
    tcc_active && !pkg_deep_idle && can_drive |=> alarm_line_n_oe)
    else $error("hot alarm not driven outside deep idle");
  AST_TRIP: assert property ( // RQ12
    cat_temp_reached |=> !thermal_trip_n && pkg_shutdown ##1 !thermal_trip_n)
    else $error("thermal trip not latched");
  AST_CRIT: assert property ( // RQ13
    crit_status |-> crit_sticky)
    else $error("critical status without sticky bit");
  AST_TCC_DUTY: assert property ( // RQ14
    tcc_mod_on && slot_idx >= TCC_ON_SLOTS |=> !core_clk_run[0])
    else $error("circuit duty not applied");
  AST_IO_WINS: assert property ( // RQ15
    !tcc_mod_on && io_mod_en && io_duty != 3'h0 &&
    slot_idx >= {io_duty, 1'b0} |=> !core_clk_run[1])
    else $error("legacy I/O duty not applied");

endmodule
`default_nettype wire

// file: hw/tat_pkg.sv
// Shared constants and types for the thermal alarm and throttle control.
// Assumes a single 40 MHz system clock; all times derive from CLK_MHZ.
package tat_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int QUICK_RESP_US = 1;
  localparam int QUICK_RESP_CYC = QUICK_RESP_US * CLK_MHZ;
  localparam int EXT_RESP_US = 100;
  localparam int EXT_RESP_CYC = EXT_RESP_US * CLK_MHZ;
  localparam int MOD_PERIOD_US = 32;
  localparam int MOD_PERIOD_CYC = MOD_PERIOD_US * CLK_MHZ;
  localparam int DUTY_SLOTS = 16;
  localparam int SLOT_CYC = MOD_PERIOD_CYC / DUTY_SLOTS;
  localparam logic [6:0] SLOT_LAST = 7'(SLOT_CYC - 1);
  localparam int CONSEC_WIN_US = 1000;
  localparam int CONSEC_WIN_CYC_DEF = CONSEC_WIN_US * CLK_MHZ;
  localparam int WIN_W = 16;

  // ---------------------------------------------------------------
  // Sizes, fields and fixed values
  // ---------------------------------------------------------------
  localparam int NUM_CORES = 4;
  localparam int RATIO_W = 8;
  localparam int CTRL_W = 5;
  localparam int MOD_EN_BIT = 4;
  localparam int MOD_DUTY_HI = 3;
  localparam int MOD_DUTY_LO = 1;
  localparam int MOD_FINE_BIT = 0;
  localparam logic [3:0] TCC_ON_SLOTS = 4'h4;
  localparam logic DUTY_FINE_CAP = 1'b1;
  localparam logic [1:0] ECHO_MASK = 2'h3;
  localparam logic [7:0] RATIO_STEP = 8'h01;

  typedef enum logic [1:0] {
    TAT_IN_ONLY,
    TAT_OUT_ONLY,
    TAT_BIDIR
  } tat_mode_e;

  typedef logic [CTRL_W-1:0] tat_ctrl_t;
  typedef logic [RATIO_W-1:0] tat_ratio_t;
  typedef logic [3:0] tat_slot_t;

endpackage

// file: hw/tat_core_gate.sv
// One core's clock gate for duty-cycle modulation.
// Assumes slot_idx steps through 16 equal slots of the modulation period.
`timescale 1ns/100ps
`default_nettype none
module tat_core_gate (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Modulation sources
  input wire tat_pkg::tat_slot_t slot_idx,
  input wire logic tcc_mod_on,
  input wire logic io_mod_en,
  input wire logic [2:0] io_duty,
  input wire tat_pkg::tat_ctrl_t core_ctrl,
  // Gate
  output logic core_run
);
  import tat_pkg::*;

  wire tat_slot_t core_code;
  wire tat_slot_t sel_code;
  wire logic modulating;
  wire logic next_run;

  // Fine step reuses the low bit; coarse step forces it to zero
  assign core_code = DUTY_FINE_CAP ?
    {core_ctrl[MOD_DUTY_HI:MOD_DUTY_LO], core_ctrl[MOD_FINE_BIT]} :
    {core_ctrl[MOD_DUTY_HI:MOD_DUTY_LO], 1'b0};
  // Circuit duty beats legacy I/O, which beats the per-core control
  assign sel_code = tcc_mod_on ? TCC_ON_SLOTS : // RQ14 RQ21
                    io_mod_en ? {io_duty, 1'b0} : // RQ15 RQ19
                    core_code; // RQ17 RQ18
  assign modulating = tcc_mod_on | io_mod_en | core_ctrl[MOD_EN_BIT]; // RQ16
  // A zero code is reserved; treat it as no gating
  assign next_run = !modulating || (sel_code == 4'h0) ||
                    (slot_idx < sel_code);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_run <= 1'b1;
    end else begin
      core_run <= next_run;
    end
  end

endmodule
`default_nettype wire

// file: tb/tat_alarm_partner.sv
// Platform thermal monitor sitting on the shared open-drain alarm line.
// Assumes the bench moves hot_req just after a falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module tat_alarm_partner (
  // Monitor request
  input wire logic hot_req,
  // Device side of the wire
  input wire logic dev_oe,
  // Resolved wire
  output logic line_n
);
  logic pull;
  // ---------------------------------------------------------------
  // Wire resolution
  // ---------------------------------------------------------------
  // The monitor pulls while hot and lets go once cool
  assign pull = hot_req;
  // Pull-up: the wire is high unless some party pulls it low
  assign line_n = ~(pull | dev_oe);
endmodule
`default_nettype wire

// file: tb/tat_throttle_ctrl_test.sv
// Self-checking bench for the thermal alarm and throttle control.
// Assumes the design package and a 40 MHz clock; window shortened to 20.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end
module tat_throttle_ctrl_test;
  import tat_pkg::*;
  localparam int WIN = 20;
  localparam int WATCHDOG_CYC = 20000;
  localparam tat_ratio_t NOM = 8'h20;
  localparam tat_ratio_t LOW = 8'h08;
  logic sys_clk, rst_n, hot_req, line_n;
  tat_mode_e mode_sel;
  logic int_assert_en, int_deassert_en, crit_irq_en;
  logic tcc_active, tcc_mod_req, temp_high, cat_temp_reached;
  logic pkg_deep_idle, crit_sticky_clr, io_mod_en;
  logic [2:0] io_duty;
  tat_ctrl_t [NUM_CORES-1:0] duty_ctrl;
  logic alarm_line_n_out, alarm_line_n_oe, force_lowest_perf;
  tat_ratio_t max_ratio_limit;
  logic alarm_assert_irq, alarm_deassert_irq, thermal_irq;
  logic crit_status, crit_sticky, thermal_trip_n, pkg_shutdown;
  logic duty_fine_cap;
  logic [NUM_CORES-1:0] core_clk_run;
  int mismatches, samples_checked;

  tat_throttle_ctrl #(.CONSEC_WIN_CYC(WIN)) u_tat_throttle_ctrl (
    .sys_clk(sys_clk), .rst_n(rst_n), .mode_sel(mode_sel),
    .int_assert_en(int_assert_en), .int_deassert_en(int_deassert_en),
    .crit_irq_en(crit_irq_en), .tcc_active(tcc_active),
    .tcc_mod_req(tcc_mod_req), .temp_high(temp_high),
    .cat_temp_reached(cat_temp_reached), .pkg_deep_idle(pkg_deep_idle),
    .crit_sticky_clr(crit_sticky_clr), .alarm_line_n_in(line_n),
    .alarm_line_n_out(alarm_line_n_out),
    .alarm_line_n_oe(alarm_line_n_oe), .max_ratio_nominal(NOM),
    .lowest_ratio(LOW), .force_lowest_perf(force_lowest_perf),
    .max_ratio_limit(max_ratio_limit),
    .alarm_assert_irq(alarm_assert_irq),
    .alarm_deassert_irq(alarm_deassert_irq), .thermal_irq(thermal_irq),
    .crit_status(crit_status), .crit_sticky(crit_sticky),
    .thermal_trip_n(thermal_trip_n), .pkg_shutdown(pkg_shutdown),
    .core_duty_ctrl(duty_ctrl), .io_mod_en(io_mod_en),
    .io_duty(io_duty), .duty_fine_cap(duty_fine_cap),
    .core_clk_run(core_clk_run)
  );

  tat_alarm_partner u_tat_alarm_partner (
    .hot_req(hot_req), .dev_oe(alarm_line_n_oe), .line_n(line_n)
  );

  always #12.5 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Counting over a whole period makes the result independent of phase
  task automatic measure(input int e0, input int e1);
    int cnt[NUM_CORES] = '{default: 0};
    cyc(3);
    repeat (MOD_PERIOD_CYC) begin
      @(negedge sys_clk);
      for (int i = 0; i < NUM_CORES; i++) cnt[i] += int'(core_clk_run[i]);
    end
    `CHK(cnt[0], e0)
    for (int i = 1; i < NUM_CORES; i++) `CHK(cnt[i], e1)
  endtask

  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0; rst_n = 1'b0; hot_req = 1'b0; mode_sel = TAT_IN_ONLY;
    int_assert_en = 1'b1; int_deassert_en = 1'b1; crit_irq_en = 1'b1;
    tcc_active = 1'b0; tcc_mod_req = 1'b0; temp_high = 1'b0;
    cat_temp_reached = 1'b0; pkg_deep_idle = 1'b0; crit_sticky_clr = 1'b0;
    io_mod_en = 1'b0; io_duty = 3'h0; duty_ctrl = '0;
    mismatches = 0; samples_checked = 0;
    cyc(16);
    `CHK(alarm_line_n_oe, 1'b0)
    `CHK(thermal_trip_n, 1'b1)
    rst_n = 1'b1;
    cyc(2);
    `CHK(duty_fine_cap, DUTY_FINE_CAP)
    `CHK(max_ratio_limit, NOM)
    tcc_active = 1'b1;
    cyc(3);
    `CHK(alarm_line_n_oe, 1'b0)
    tcc_active = 1'b0;
    hot_req = 1'b1;
    cyc(2);
    `CHK(force_lowest_perf, 1'b0)
    cyc(1);
    `CHK(force_lowest_perf, 1'b1)
    `CHK(alarm_assert_irq, 1'b1)
    cyc(1);
    `CHK(alarm_assert_irq, 1'b0)
    `CHK(max_ratio_limit, NOM)
    measure(MOD_PERIOD_CYC, MOD_PERIOD_CYC);
    `CHK(force_lowest_perf, 1'b1)
    hot_req = 1'b0;
    cyc(3);
    `CHK(force_lowest_perf, 1'b0)
    `CHK(alarm_deassert_irq, 1'b1)
    // Second assertion inside the window counts as consecutive
    hot_req = 1'b1;
    int_assert_en = 1'b0;
    cyc(3);
    `CHK(force_lowest_perf, 1'b1)
    `CHK(alarm_assert_irq, 1'b0)
    int_assert_en = 1'b1;
    cyc(2);
    `CHK(max_ratio_limit, NOM - RATIO_STEP)
    hot_req = 1'b0;
    cyc(3 + WIN / 2);
    `CHK(max_ratio_limit, NOM - RATIO_STEP)
    cyc(2 * WIN);
    `CHK(max_ratio_limit, NOM)
    mode_sel = TAT_BIDIR;
    tcc_active = 1'b1;
    cyc(3);
    `CHK(alarm_line_n_oe, 1'b1)
    hot_req = 1'b1;
    cyc(8);
    `CHK(force_lowest_perf, 1'b0)
    tcc_active = 1'b0;
    cyc(12);
    `CHK(force_lowest_perf, 1'b1)
    `CHK(max_ratio_limit, NOM)
    hot_req = 1'b0;
    tcc_active = 1'b1;
    cyc(6);
    pkg_deep_idle = 1'b1;
    cyc(2);
    `CHK(alarm_line_n_oe, 1'b0)
    pkg_deep_idle = 1'b0;
    cyc(2);
    `CHK(alarm_line_n_oe, 1'b1)
    mode_sel = TAT_OUT_ONLY;
    tcc_active = 1'b0;
    cyc(2);
    hot_req = 1'b1;
    cyc(8);
    `CHK(force_lowest_perf, 1'b0)
    tcc_active = 1'b1;
    cyc(2);
    `CHK(alarm_line_n_oe, 1'b1)
    `CHK(alarm_line_n_out, 1'b0)
    hot_req = 1'b0;
    tcc_active = 1'b0;
    mode_sel = TAT_IN_ONLY;
    cyc(8);
    tcc_active = 1'b1;
    temp_high = 1'b1;
    cyc(1);
    `CHK(crit_status, 1'b1)
    `CHK(thermal_irq, 1'b1)
    temp_high = 1'b0;
    cyc(2);
    `CHK(crit_status, 1'b0)
    `CHK(crit_sticky, 1'b1)
    crit_sticky_clr = 1'b1;
    cyc(2);
    `CHK(crit_sticky, 1'b0)
    crit_sticky_clr = 1'b0;
    tcc_active = 1'b0;
    duty_ctrl[0] = 5'h14;
    measure(4 * SLOT_CYC, MOD_PERIOD_CYC);
    duty_ctrl[0] = 5'h13;
    measure(3 * SLOT_CYC, MOD_PERIOD_CYC);
    duty_ctrl = {NUM_CORES{5'h14}};
    io_mod_en = 1'b1;
    io_duty = 3'h3;
    measure(6 * SLOT_CYC, 6 * SLOT_CYC);
    tcc_active = 1'b1;
    tcc_mod_req = 1'b1;
    measure(4 * SLOT_CYC, 4 * SLOT_CYC);
    cat_temp_reached = 1'b1;
    cyc(1);
    `CHK(pkg_shutdown, 1'b1)
    cat_temp_reached = 1'b0;
    cyc(3);
    `CHK(thermal_trip_n, 1'b0)
    complete_run();
  end

  // A hang counts as a mismatch and ends through the same verdict
  initial begin
    #(WATCHDOG_CYC * 25);
    mismatches++;
    complete_run();
  end
endmodule
`undef CHK
`default_nettype wire
